// file: include/txsb_defines.svh
`ifndef TXSB_DEFINES_SVH
`define TXSB_DEFINES_SVH
`define TXSB_ADDR_STATUS 8'h00
`define TXSB_ADDR_MASK 8'h04
`define TXSB_ADDR_LEVEL 8'h08
`define TXSB_BIT_OVF 7
`define TXSB_BIT_UNF 6
`define TXSB_BIT_SLIP 5
`define TXSB_STATUS_RST 8'h00
`define TXSB_MASK_RST 8'h00
`define TXSB_HTRANS_NONSEQ 2'h2
`define TXSB_HSIZE_WORD 3'h2
`endif

// file: include/txsb_pkg.sv
package txsb_pkg;
  typedef enum logic [1:0] {
    TXSB_IDLE = 2'b00,
    TXSB_RD = 2'b01,
    TXSB_WR = 2'b10
  } txsb_phase_t;
endpackage

// file: src/txsb_flag.sv
`timescale 1ns/1ps
`default_nettype none
module txsb_flag (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_q
);
  typedef struct packed {
    logic f;
  } txsb_flag_st_t;
  txsb_flag_st_t s_q;
  txsb_flag_st_t s_d;
  always_comb
  begin
    s_d = s_q;
    // set wins over the clearing read
    if (set_i)
    begin
      s_d.f = 1'b1;
    end
    else if (clr_i)
    begin
      s_d.f = 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign flag_q = s_q.f;
endmodule
`default_nettype wire

// file: src/txsb_ring.sv
`timescale 1ns/1ps
`default_nettype none
// frame-granular slip buffer: depth counted in whole frames
module txsb_ring #(
  parameter int DW = 8,
  parameter int FRAME = 4,
  parameter int NFR = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_q,
  output logic ovf_q,
  output logic unf_q,
  output logic [$clog2(FRAME*NFR+1)-1:0] level_o
);
  localparam int D = FRAME * NFR;
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][DW-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] cnt;
    logic [DW-1:0] rdata;
    logic ovf;
    logic unf;
  } txsb_ring_st_t;
  txsb_ring_st_t s_q;
  txsb_ring_st_t s_d;
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p, input int n);
    int t;
    t = (int'(p) + n) % D;
    return AW'(t);
  endfunction
  always_comb
  begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    s_d.unf = 1'b0;
    if (rd_i)
    begin
      if (s_q.cnt == '0)
      begin
        // replay the frame just sent
        s_d.rp = step(s_q.rp, D - FRAME);
        s_d.cnt = LW'(FRAME - 1);
        s_d.rdata = s_q.mem[step(s_q.rp, D - FRAME)];
        s_d.unf = 1'b1;
        s_d.rp = step(s_q.rp, D - FRAME + 1);
      end
      else
      begin
        s_d.rdata = s_q.mem[s_q.rp];
        s_d.rp = step(s_q.rp, 1);
        s_d.cnt = s_q.cnt - LW'(1);
      end
    end
    if (wr_i)
    begin
      s_d.mem[s_q.wp] = wdata_i;
      if (s_q.cnt == LW'(D) && !rd_i)
      begin
        // drop oldest frame; new word takes its first slot
        s_d.rp = step(s_q.rp, FRAME);
        s_d.wp = step(s_q.wp, 1);
        s_d.cnt = LW'(D - FRAME + 1);
        s_d.ovf = 1'b1;
      end
      else
      begin
        s_d.wp = step(s_q.wp, 1);
        s_d.cnt = s_d.cnt + LW'(1);
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign rdata_q = s_q.rdata;
  assign ovf_q = s_q.ovf;
  assign unf_q = s_q.unf;
  assign level_o = s_q.cnt;
  a_ovf_level: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_q |-> level_o == LW'(D - FRAME + 1)) else $error("overflow did not drop one frame");
  a_unf_level: assert property (@(posedge hclk) disable iff (!hresetn)
    unf_q |-> level_o == LW'(FRAME - 1) + LW'($past(wr_i))) else $error("underflow did not replay one frame");
endmodule
`default_nettype wire

// file: src/txsb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "txsb_defines.svh"
module txsb_top #(
  parameter int DW = 8,
  parameter int FRAME = 4,
  parameter int NFR = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sys_wr,
  input wire logic [DW-1:0] sys_wdata,
  input wire logic line_rd,
  output logic [DW-1:0] line_rdata,
  output logic irq
);
  localparam int LW = $clog2(FRAME * NFR + 1);
  typedef struct packed {
    txsb_pkg::txsb_phase_t ph;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [31:0] rdata;
    logic irq;
    logic clr;
  } txsb_top_st_t;
  txsb_top_st_t s_q;
  txsb_top_st_t s_d;
  logic ovf_ev;
  logic unf_ev;
  logic [LW-1:0] level;
  logic [7:0] status;
  logic [2:0] flags;
  logic [2:0] sets;
  logic rd_status;
  // clear in the address phase, same edge as the snapshot, so no event is lost
  assign rd_status = hsel && hready && htrans == `TXSB_HTRANS_NONSEQ && !hwrite
    && haddr[7:0] == `TXSB_ADDR_STATUS;
  assign sets[2] = ovf_ev;
  assign sets[1] = unf_ev;
  assign sets[0] = ovf_ev | unf_ev;
  txsb_ring #(.DW(DW), .FRAME(FRAME), .NFR(NFR)) u_ring (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_i(sys_wr),
    .wdata_i(sys_wdata),
    .rd_i(line_rd),
    .rdata_q(line_rdata),
    .ovf_q(ovf_ev),
    .unf_q(unf_ev),
    .level_o(level)
  );
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_flag
      txsb_flag u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_i(sets[gi]),
        .clr_i(rd_status),
        .flag_q(flags[gi])
      );
    end
  endgenerate
  always_comb
  begin
    status = `TXSB_STATUS_RST;
    status[`TXSB_BIT_OVF] = flags[2];
    status[`TXSB_BIT_UNF] = flags[1];
    status[`TXSB_BIT_SLIP] = flags[0];
  end
  always_comb
  begin
    s_d = s_q;
    s_d.clr = 1'b0;
    // data phase of previous transfer
    if (s_q.ph == txsb_pkg::TXSB_WR && s_q.addr == `TXSB_ADDR_MASK)
    begin
      s_d.mask = hwdata[7:0];
    end
    s_d.ph = txsb_pkg::TXSB_IDLE;
    if (hsel && hready && htrans == `TXSB_HTRANS_NONSEQ)
    begin
      s_d.addr = haddr[7:0];
      s_d.ph = hwrite ? txsb_pkg::TXSB_WR : txsb_pkg::TXSB_RD;
      if (!hwrite)
      begin
        case (haddr[7:0])
          `TXSB_ADDR_STATUS:
          begin
            s_d.rdata = {24'h000000, status};
            s_d.clr = 1'b1;
          end
          `TXSB_ADDR_MASK: s_d.rdata = {24'h000000, s_q.mask};
          `TXSB_ADDR_LEVEL: s_d.rdata = 32'(level);
          default: s_d.rdata = 32'h00000000;
        endcase
      end
    end
    // irq follows the flags' next value so it drops with the clearing read
    s_d.irq = |(({sets, 5'h00} | (status & ~{8{rd_status}})) & s_d.mask);
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = s_q.irq;
  a_ovf_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_ev |=> status[`TXSB_BIT_OVF] && status[`TXSB_BIT_SLIP]) else $error("overflow flag not set");
  a_unf_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    unf_ev |=> status[`TXSB_BIT_UNF] && status[`TXSB_BIT_SLIP]) else $error("underflow flag not set");
  a_slip_any: assert property (@(posedge hclk) disable iff (!hresetn)
    status[`TXSB_BIT_SLIP] == (status[`TXSB_BIT_SLIP] && $past(status[`TXSB_BIT_SLIP]) && !$past(rd_status))
    || $past(ovf_ev || unf_ev)) else $error("slip flag set without a slip");
  a_read_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status && !ovf_ev && !unf_ev |=> status == 8'h00) else $error("read did not clear flags");
  a_rst_zero: assert property (@(posedge hclk)
    !hresetn |-> status == 8'h00) else $error("flags not zero in reset");
  a_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.clr |-> hrdata[7:0] == $past(status)) else $error("status read wrong value");
endmodule
`default_nettype wire

// file: verification/txsb_stream_model.sv
`timescale 1ns/1ps
`default_nettype none
// frame source and line framer: one word per request cycle
module txsb_stream_model #(
  parameter int DW = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_req,
  input wire logic rd_req,
  output logic sys_wr,
  output logic [DW-1:0] sys_wdata,
  output logic line_rd
);
  logic [DW-1:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sys_wr <= 1'b0;
      line_rd <= 1'b0;
      cnt_q <= '0;
      sys_wdata <= '0;
    end
    else
    begin
      sys_wr <= wr_req;
      line_rd <= rd_req;
      cnt_q <= cnt_q + DW'(wr_req);
      // idle data toggles so no stale word looks valid
      sys_wdata <= wr_req ? cnt_q : ~sys_wdata;
    end
  end
endmodule
`default_nettype wire

// file: verification/tx_slip_buffer_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tx_slip_buffer_status_bench;
  logic hclk, hresetn, hsel, hwrite, hrdy, hresp, wr_req, rd_req, sys_wr, line_rd, irq;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] sys_wdata, line_rdata;
  int n_mismatch, samples_checked;
  txsb_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .sys_wr(sys_wr), .sys_wdata(sys_wdata), .line_rd(line_rd),
    .line_rdata(line_rdata), .irq(irq));
  txsb_stream_model mdl (.hclk(hclk), .hresetn(hresetn), .wr_req(wr_req), .rd_req(rd_req),
    .sys_wr(sys_wr), .sys_wdata(sys_wdata), .line_rd(line_rd));
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic stream(input logic w, input logic r, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      wr_req <= w;
      rd_req <= r;
    end
    @(posedge hclk);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  initial
  begin
    hsel = 1'b1;
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wr_req = 1'b0;
    rd_req = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0, 32'h0, rv);
    chk("status", 32'h0, rv);
    bus(1'b0, 32'h10, 32'h0, rv);
    chk("unmapped", 32'h0, rv);
    stream(1'b0, 1'b1, 1);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b0, 32'h0, 32'h0, rv);
    chk("status", 32'h60, rv);
    bus(1'b0, 32'h8, 32'h0, rv);
    chk("level", 32'h3, rv);
    bus(1'b0, 32'h0, 32'h0, rv);
    chk("status", 32'h0, rv);
    $display("test underflow done");
    bus(1'b1, 32'h4, 32'he0, rv);
    bus(1'b0, 32'h4, 32'h0, rv);
    chk("mask", 32'he0, rv);
    stream(1'b1, 1'b0, 5);
    bus(1'b0, 32'h8, 32'h0, rv);
    chk("level", 32'h8, rv);
    chk("irq", 32'h0, {31'h0, irq});
    stream(1'b1, 1'b0, 1);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, 32'h0, 32'h0, rv);
    chk("status", 32'ha0, rv);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b0, 32'h8, 32'h0, rv);
    chk("level", 32'h5, rv);
    $display("test overflow done");
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int k = 1; k <= 5; k++)
    begin
      stream(1'b0, 1'b1, 1);
      chk("line data", 32'(k), {24'h0, line_rdata});
    end
    for (int k = 2; k <= 5; k++)
    begin
      stream(1'b0, 1'b1, 1);
      chk("replay data", 32'(k), {24'h0, line_rdata});
    end
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, 32'h0, 32'h0, rv);
    chk("status", 32'h60, rv);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test replay done");
    finish_test();
  end
endmodule
`default_nettype wire
